// ### design/wake_switch_swk_status_bank.sv
`timescale 1ns/10ps

module wake_switch_swk_status_bank
   import swk_status_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       soft_rst_i,
   input  wire logic       restart_i,
   input  wire logic       dev_strap_i,
   input  wire logic       pullup_detect_i,
   input  wire logic [2:0] wake_pin_i,
   input  wire logic [2:0] wake_cyclic_i,
   input  wire logic [2:0] wake_sample_i,
   input  wire logic [1:0] io_pin_i,
   input  wire logic [1:0] io_is_gpio_i,
   input  wire io_cfg_t    io_cfg_i [2],
   input  wire sbc_mode_t  sbc_mode_i,
   input  wire logic [3:0] hs_overload_i,
   input  wire logic [3:0] hs_open_load_i,
   input  wire logic [2:0] can_mode_i,
   input  wire logic       can_mode_wr_i,
   input  wire logic       config_valid_bit_i,
   input  wire logic       config_error_i,
   input  wire logic       frame_ok_i,
   input  wire logic       frame_error_i,
   input  wire logic       silence_exceeded_i,
   input  wire logic       wup_detect_i,
   input  wire logic       wuf_detect_i,
   input  wire logic       swk_clear_i,
   input  wire logic       rd_en_i,
   input  wire logic [6:0] rd_addr_i,
   output logic      [7:0] rd_data_o,
   output logic            partial_wake_system_error_o,
   output logic            partial_wake_active_o
);

   logic [2:0] wake_level;
   logic [1:0] io_level;
   logic [7:0] overload_flags;
   logic [7:0] open_load_flags;
   logic       lvl_clear_hi;
   logic       any_reset;
   logic       dev_q;
   logic       cfg_q;
   logic       sync_q;
   logic       sil_q;
   logic       act_q;
   logic       wup_q;
   logic       wuf_q;
   logic       sys_error_q;
   logic [5:0] ecnt_q;
   logic [2:0] can_mode_q;
   logic [7:0] input_level_status;
   logic [7:0] selective_wake_status;
   logic [7:0] selective_wake_error_count;
   logic       mode_change;
   logic       swk_enabled;

   // Address match used by both read data mux and read-clear strobes
   function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] r);
      addr_hit = (a == r);
   endfunction

   assign any_reset    = soft_rst_i;
   assign lvl_clear_hi = soft_rst_i;
   assign swk_enabled  = can_mode_i[CAN_MODE_SWK_BIT];

   // Strap levels tracked continuously; pins are synchronous inputs
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dev_q <= 1'b0;
         cfg_q <= 1'b0;
      end else begin
         dev_q <= dev_strap_i;
         cfg_q <= pullup_detect_i;
      end
   end

   // Wake inputs: live level, or last sample in cyclic/wake mode
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_wake
         level_sampler u_wake (
            .clk_i    (clk_i),
            .arst_n_i (arst_n_i),
            .clear_i  (1'b0),
            .update_i (wake_cyclic_i[gi] ? wake_sample_i[gi] : 1'b1),
            .pin_i    (wake_pin_i[gi]),
            .level_o  (wake_level[gi])
         );
      end
      // General I/O levels: no cyclic sensing, refresh gated by mode and config
      for (gi = 0; gi < 2; gi++) begin : g_io
         level_sampler u_io (
            .clk_i    (clk_i),
            .arst_n_i (arst_n_i),
            .clear_i  (lvl_clear_hi),
            .update_i (io_is_gpio_i[gi] && io_cfg_i[gi] != IO_OFF &&
                       (sbc_mode_i == MODE_NORMAL || sbc_mode_i == MODE_STOP)),
            .pin_i    (io_pin_i[gi]),
            .level_o  (io_level[gi])
         );
      end
   endgenerate

   // Bit 3 reserved, always zero
   assign input_level_status = {dev_q, cfg_q, io_level[1], io_level[0], 1'b0,
                                wake_level};

   // High-side fault flags, cleared by reading the register
   fault_flag_bank u_overload (
      .clk_i        (clk_i),
      .arst_n_i     (arst_n_i),
      .soft_rst_i   (any_reset),
      .restart_i    (restart_i),
      .detect_i     (hs_overload_i),
      .read_clear_i (rd_en_i && addr_hit(rd_addr_i, OVERLOAD_ADDR)),
      .flags_o      (overload_flags)
   );

   fault_flag_bank u_open_load (
      .clk_i        (clk_i),
      .arst_n_i     (arst_n_i),
      .soft_rst_i   (any_reset),
      .restart_i    (restart_i),
      .detect_i     (hs_open_load_i),
      .read_clear_i (rd_en_i && addr_hit(rd_addr_i, OPEN_LOAD_ADDR)),
      .flags_o      (open_load_flags)
   );

   // Mode write that changes the field and is not the blocked value
   assign mode_change = can_mode_wr_i && (can_mode_i != can_mode_q) &&
                        (can_mode_i != CAN_MODE_NO_SWK);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         can_mode_q <= 3'h0;
      end else if (can_mode_wr_i) begin
         can_mode_q <= can_mode_i;
      end
   end

   // System error only set while selective wake enabled; host clear applies in any mode
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sys_error_q <= 1'b0;
      end else if (soft_rst_i) begin
         sys_error_q <= 1'b0;
      end else if (swk_enabled && (config_error_i || ecnt_q == ECNT_OVERFLOW)) begin
         sys_error_q <= 1'b1;
      end else if (swk_clear_i) begin
         sys_error_q <= 1'b0;
      end
   end

   // Frame error counter: count errors up to overflow, good frames count down only below overflow
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ecnt_q <= 6'h00;
      end else if (soft_rst_i) begin
         ecnt_q <= 6'h00;
      end else if (frame_error_i && ecnt_q != ECNT_OVERFLOW) begin
         ecnt_q <= ecnt_q + 6'h01;
      end else if (frame_ok_i && ecnt_q != 6'h00 && ecnt_q != ECNT_OVERFLOW) begin
         ecnt_q <= ecnt_q - 6'h01;
      end
   end

   // Activation state: restart retains bits 6 and 3:0 as they were
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         act_q <= 1'b0;
      end else if (soft_rst_i) begin
         act_q <= 1'b0;
      end else if (!swk_enabled || sys_error_q || !config_valid_bit_i) begin
         act_q <= 1'b0;
      end else if (mode_change) begin
         act_q <= 1'b1;
      end
   end

   // Event flags: hardware set wins over host clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sync_q <= 1'b0;
         sil_q  <= 1'b0;
         wup_q  <= 1'b0;
         wuf_q  <= 1'b0;
      end else if (soft_rst_i) begin
         sync_q <= 1'b0;
         sil_q  <= 1'b0;
         wup_q  <= 1'b0;
         wuf_q  <= 1'b0;
      end else begin
         sync_q <= (frame_ok_i && act_q) || (sync_q && !swk_clear_i);
         sil_q  <= (silence_exceeded_i && act_q) || (sil_q && !swk_clear_i);
         wup_q  <= wup_detect_i || (wup_q && !swk_clear_i);
         wuf_q  <= wuf_detect_i || (wuf_q && !swk_clear_i);
      end
   end

   // Reserved bits 7 and 5:4 tied low
   assign selective_wake_status = {1'b0, sync_q, 2'b00, sil_q, act_q, wup_q, wuf_q};
   assign selective_wake_error_count = {2'b00, ecnt_q};

   // Registered read data; unmapped addresses read zero
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_data_o <= 8'h00;
      end else if (rd_en_i) begin
         if (addr_hit(rd_addr_i, INPUT_LEVEL_ADDR)) begin
            rd_data_o <= input_level_status;
         end else if (addr_hit(rd_addr_i, OVERLOAD_ADDR)) begin
            rd_data_o <= overload_flags;
         end else if (addr_hit(rd_addr_i, OPEN_LOAD_ADDR)) begin
            rd_data_o <= open_load_flags;
         end else if (addr_hit(rd_addr_i, SWK_STATUS_ADDR)) begin
            rd_data_o <= selective_wake_status;
         end else if (addr_hit(rd_addr_i, SWK_ERR_COUNT_ADDR)) begin
            rd_data_o <= selective_wake_error_count;
         end else begin
            rd_data_o <= 8'h00;
         end
      end
   end

   assign partial_wake_system_error_o = sys_error_q;
   assign partial_wake_active_o       = act_q;

   strap_track_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> dev_q == $past(dev_strap_i))
      else $error("Development level not tracking strap");

   pullup_track_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      1'b1 |=> cfg_q == $past(pullup_detect_i))
      else $error("Pull-up status not tracking");

   io_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (sbc_mode_i == MODE_OTHER && !soft_rst_i) |=> $stable(io_level))
      else $error("I/O level refreshed outside normal or stop");

   reserved_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      rd_en_i |=> rd_data_o[3] == 1'b0 || $past(rd_addr_i) != INPUT_LEVEL_ADDR)
      else $error("Reserved bit read non-zero");

   blocked_mode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!act_q && can_mode_wr_i && can_mode_i == CAN_MODE_NO_SWK) |=> !act_q)
      else $error("Selective wake activated by blocked mode");

   active_cond_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      act_q |-> $past(swk_enabled) && !$past(sys_error_q) && $past(config_valid_bit_i))
      else $error("Selective wake active without conditions");

   sys_error_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (swk_enabled && config_error_i && !soft_rst_i) |=> sys_error_q)
      else $error("System error not set on config error");

   soft_reset_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      soft_rst_i |=> selective_wake_status == 8'h00 && ecnt_q == 6'h00)
      else $error("Wake status not cleared by soft reset");

   // Level, fault and wake event paths, each checked one cycle after its cause
   wake_level_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wake_cyclic_i == 3'h0) |=> wake_level == $past(wake_pin_i))
      else $error("Wake level not following pins");

   cyclic_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wake_cyclic_i[0] && !wake_sample_i[0]) |=> $stable(wake_level[0]))
      else $error("Cyclic wake level moved without a sample");

   cyclic_sample_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wake_cyclic_i[0] && wake_sample_i[0]) |=> wake_level[0] == $past(wake_pin_i[0]))
      else $error("Cyclic wake level not rewritten on sample");

   io_refresh_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (io_is_gpio_i[1] && io_cfg_i[1] == IO_HIGH_SIDE && sbc_mode_i == MODE_NORMAL &&
       !soft_rst_i) |=> io_level[1] == $past(io_pin_i[1]))
      else $error("I/O level not shown for a switch pin");

   io_soft_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      soft_rst_i |=> io_level == 2'b00 && input_level_status[3] == 1'b0)
      else $error("Input level bits not cleared by soft reset");

   overload_read_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_en_i && rd_addr_i == OVERLOAD_ADDR) |=> rd_data_o == $past(overload_flags))
      else $error("Overload flags not returned on read");

   open_load_read_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_en_i && rd_addr_i == OPEN_LOAD_ADDR) |=> rd_data_o == $past(open_load_flags))
      else $error("Open-load flags not returned on read");

   restart_keep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (restart_i && !soft_rst_i) |=>
      (overload_flags & $past(overload_flags)) == $past(overload_flags) &&
      (open_load_flags & $past(open_load_flags)) == $past(open_load_flags))
      else $error("Fault flag lost on restart");

   sync_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (frame_ok_i && act_q && !soft_rst_i) |=> sync_q)
      else $error("Sync flag not set on good frame");

   silence_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (silence_exceeded_i && act_q && !soft_rst_i) |=> sil_q)
      else $error("Silence flag not set while active");

   wake_event_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wup_detect_i && wuf_detect_i && !soft_rst_i) |=> wup_q && wuf_q)
      else $error("Wake pattern or frame flag not set");

   count_restart_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (restart_i && !soft_rst_i && !frame_error_i && !frame_ok_i) |=> $stable(ecnt_q))
      else $error("Error count changed by restart");

   sticky_status_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (sync_q && !swk_clear_i && !soft_rst_i) |=> sync_q)
      else $error("Sync flag cleared without host");

   error_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!swk_enabled && !swk_clear_i && !soft_rst_i) |=> $stable(sys_error_q))
      else $error("System error updated while disabled");

   activation_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (mode_change && swk_enabled && !sys_error_q && config_valid_bit_i && !soft_rst_i)
      |=> act_q)
      else $error("Selective wake not activated on mode change");

endmodule

// ### design/swk_status_pkg.sv
package swk_status_pkg;

   // Register offsets (7-bit status address space)
   localparam logic [6:0] INPUT_LEVEL_ADDR   = 7'h48;
   localparam logic [6:0] OVERLOAD_ADDR      = 7'h54;
   localparam logic [6:0] OPEN_LOAD_ADDR     = 7'h55;
   localparam logic [6:0] SWK_STATUS_ADDR    = 7'h70;
   localparam logic [6:0] SWK_ERR_COUNT_ADDR = 7'h71;

   // Input level field positions
   localparam int LVL_DEV_BIT  = 7;
   localparam int LVL_CFG_BIT  = 6;
   localparam int LVL_IO2_BIT  = 5;
   localparam int LVL_IO1_BIT  = 4;
   localparam int LVL_WK_LSB   = 0;

   // Selective wake status field positions
   localparam int SWK_SYNC_BIT = 6;
   localparam int SWK_SIL_BIT  = 3;
   localparam int WAKE_ACT_BIT = 2;
   localparam int SWK_WUP_BIT  = 1;
   localparam int SWK_WUF_BIT  = 0;

   // Restart keep masks and reset values
   localparam logic [7:0] FLAG_RESET_VAL   = 8'h00;
   localparam logic [7:0] HS_RESTART_KEEP  = 8'h0f;
   localparam logic [7:0] SWK_RESTART_KEEP = 8'h4f;
   localparam logic [7:0] ECNT_RESTART_KEEP = 8'h3f;
   localparam logic [7:0] LVL_POR_KEEP     = 8'hc7;
   localparam logic [7:0] LVL_RESTART_KEEP = 8'hf7;

   // Transceiver mode value that never activates selective wake
   localparam logic [2:0] CAN_MODE_NO_SWK = 3'h4;
   localparam int         CAN_MODE_SWK_BIT = 2;

   // Error counter overflow threshold
   localparam logic [5:0] ECNT_OVERFLOW = 6'h20;

   typedef enum logic [1:0] {
      MODE_OTHER,
      MODE_NORMAL,
      MODE_STOP
   } sbc_mode_t;

   typedef enum logic [1:0] {
      IO_OFF,
      IO_WAKE,
      IO_LOW_SIDE,
      IO_HIGH_SIDE
   } io_cfg_t;

endpackage

// ### design/fault_flag_bank.sv
`timescale 1ns/10ps
// Four read-clear fault flags with restart retention
module fault_flag_bank
   import swk_status_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       soft_rst_i,
   input  wire logic       restart_i,
   input  wire logic [3:0] detect_i,
   input  wire logic       read_clear_i,
   output logic      [7:0] flags_o
);

   logic [3:0] flag_q;

   // Set wins over a simultaneous read-clear so no event is lost
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_q <= 4'h0;
      end else if (soft_rst_i) begin
         flag_q <= 4'h0;
      end else if (restart_i) begin
         flag_q <= flag_q | detect_i;
      end else if (read_clear_i) begin
         flag_q <= detect_i;
      end else begin
         flag_q <= flag_q | detect_i;
      end
   end

   assign flags_o = {4'h0, flag_q};

   flag_persist_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (read_clear_i && !soft_rst_i && detect_i[0]) |=> flag_q[0])
      else $error("Persisting fault lost after read-clear");

   flag_sticky_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (flag_q[1] && !read_clear_i && !soft_rst_i) |=> flag_q[1])
      else $error("Fault flag cleared without host");

endmodule

// ### design/level_sampler.sv
`timescale 1ns/10ps
// Level capture for one pin: refresh on enable, force low on clear
module level_sampler (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic clear_i,
   input  wire logic update_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic level_q;

   // Clear has priority so a reset value is not overwritten same cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         level_q <= 1'b0;
      end else if (clear_i) begin
         level_q <= 1'b0;
      end else if (update_i) begin
         level_q <= pin_i;
      end
   end

   assign level_o = level_q;

endmodule

// ### sim/host_model.sv
`timescale 1ns/10ps
// Host side of the status read port: one byte per request, answer one cycle later
module host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rd_data_i,
   output logic            rd_en_o,
   output logic      [6:0] rd_addr_o
);
   // Idle with no request and an unmapped address
   initial begin
      rd_en_o   = 1'b0;
      rd_addr_o = 7'h7f;
   end

   // Request held across the taking edge; data taken once that edge's update lands
   // A second read of a fault register sees only what was set again
   task automatic rd_byte(input logic [6:0] addr, output logic [7:0] data);
      @(posedge clk_i);
      #1;
      rd_en_o   = 1'b1;
      rd_addr_o = addr;
      @(posedge clk_i);
      #1;
      rd_en_o   = 1'b0;
      rd_addr_o = ~addr;  // Released address changes so a stale value cannot pass
      data      = rd_data_i;
   endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import swk_status_pkg::*;
   typedef struct {
      logic       dev;
      logic       pull;
      logic [2:0] wk;
      logic [1:0] io;
      io_cfg_t    cfg;
      sbc_mode_t  mode;
      logic [7:0] exp;
   } lvl_row_t;
   logic       clk_i = 0, arst_n_i = 0, soft_rst = 0, restart = 0, dev = 1, pull = 1;
   logic [2:0] wk_pin = 3'h3, wk_cyc = 3'h0, wk_smp = 3'h0, can_mode = 3'h0;
   logic [1:0] io_pin = 2'h3, io_gpio = 2'h3;
   io_cfg_t    io_cfg [2] = '{IO_OFF, IO_OFF};
   sbc_mode_t  mode = MODE_OTHER;
   logic [3:0] hs_oc = 4'h0, hs_ol = 4'h0;
   logic       can_wr = 0, cfg_ok = 0, f_ok = 0, f_err = 0, sil = 0, wup = 0, wuf = 0;
   logic       swk_clr = 0, cfg_err = 0, rd_en, sys_err, active;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   int         n_fail = 0;
   int         compares = 0;
   logic [6:0] zero_addr [5] = '{OVERLOAD_ADDR, OPEN_LOAD_ADDR, SWK_STATUS_ADDR,
                                 SWK_ERR_COUNT_ADDR, 7'h01};
   // Level table: strap, pull-up, wake pins, io pins, io config, mode, expected byte
   lvl_row_t   rows [5] = '{'{1, 0, 3'h5, 2'h3, IO_WAKE, MODE_NORMAL, 8'hb5},
                            '{0, 1, 3'h2, 2'h1, IO_LOW_SIDE, MODE_STOP, 8'h52},
                            '{1, 1, 3'h7, 2'h2, IO_WAKE, MODE_OTHER, 8'hd7},
                            '{0, 0, 3'h0, 2'h2, IO_OFF, MODE_NORMAL, 8'h10},
                            '{0, 0, 3'h0, 2'h2, IO_HIGH_SIDE, MODE_NORMAL, 8'h20}};

   wake_switch_swk_status_bank dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .soft_rst_i(soft_rst), .restart_i(restart),
      .dev_strap_i(dev), .pullup_detect_i(pull), .wake_pin_i(wk_pin),
      .wake_cyclic_i(wk_cyc), .wake_sample_i(wk_smp), .io_pin_i(io_pin),
      .io_is_gpio_i(io_gpio), .io_cfg_i(io_cfg), .sbc_mode_i(mode),
      .hs_overload_i(hs_oc), .hs_open_load_i(hs_ol), .can_mode_i(can_mode),
      .can_mode_wr_i(can_wr), .config_valid_bit_i(cfg_ok), .config_error_i(cfg_err),
      .frame_ok_i(f_ok), .frame_error_i(f_err), .silence_exceeded_i(sil),
      .wup_detect_i(wup), .wuf_detect_i(wuf), .swk_clear_i(swk_clr), .rd_en_i(rd_en),
      .rd_addr_i(rd_addr), .rd_data_o(rd_data), .partial_wake_system_error_o(sys_err),
      .partial_wake_active_o(active));

   host_model host (.clk_i(clk_i), .rd_data_i(rd_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr));

   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic wrap_up();
      if (n_fail == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rd(input string nm, input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd_byte(a, d);
      chk(nm, d, exp);
   endtask

   // Inputs always move one step after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic mode_wr(input logic [2:0] m);
      can_mode = m;
      can_wr = 1;
      cyc(1);
      can_wr = 0;
      cyc(4);
   endtask

   task automatic f_errs(input int n);
      repeat (n) begin
         f_err = 1;
         cyc(1);
         f_err = 0;
         cyc(1);
      end
   endtask

   // Activation latency is the design's own, so poll with a bound
   task automatic wait_act(input logic exp);
      for (int i = 0; i < 8 && active !== exp; i++) cyc(1);
      chk("active", {7'h00, active}, {7'h00, exp});
      if (active !== exp) wrap_up();
   endtask

   // Hang guard far beyond the whole sequence
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      wrap_up();
   end

   initial begin
      cyc(5);
      arst_n_i = 1;
      cyc(2);
      rd("lvl_por", INPUT_LEVEL_ADDR, 8'hc3);
      foreach (zero_addr[i]) rd("por_zero", zero_addr[i], 8'h00);
      foreach (rows[i]) begin
         {dev, pull, wk_pin, io_pin} = {rows[i].dev, rows[i].pull, rows[i].wk, rows[i].io};
         io_cfg = '{rows[i].cfg, rows[i].cfg};
         mode = rows[i].mode;
         cyc(2);
         rd("lvl_row", INPUT_LEVEL_ADDR, rows[i].exp);
      end
      // Cyclic wake input only moves on its sample strobe
      wk_cyc = 3'h1;
      wk_pin = 3'h1;
      cyc(2);
      rd("cyc_hold", INPUT_LEVEL_ADDR, 8'h20);
      wk_smp = 3'h1;
      cyc(1);
      wk_smp = 3'h0;
      wk_pin = 3'h0;
      cyc(2);
      rd("cyc_smp", INPUT_LEVEL_ADDR, 8'h21);
      mode = MODE_OTHER;
      soft_rst = 1;
      cyc(1);
      soft_rst = 0;
      rd("lvl_soft", INPUT_LEVEL_ADDR, 8'h01);
      // Read-clear fault flags, persistence and retention
      hs_oc = 4'h5;
      cyc(1);
      hs_oc = 4'h0;
      rd("oc_set", OVERLOAD_ADDR, 8'h05);
      rd("oc_clr", OVERLOAD_ADDR, 8'h00);
      hs_ol = 4'h8;
      cyc(1);
      rd("ol_set", OPEN_LOAD_ADDR, 8'h08);
      rd("ol_hold", OPEN_LOAD_ADDR, 8'h08);
      hs_ol = 4'h0;
      rd("ol_last", OPEN_LOAD_ADDR, 8'h08);
      rd("ol_clr", OPEN_LOAD_ADDR, 8'h00);
      {hs_oc, hs_ol} = 8'h21;
      cyc(1);
      {hs_oc, hs_ol, restart} = 9'h001;
      cyc(1);
      restart = 0;
      rd("oc_restart", OVERLOAD_ADDR, 8'h02);
      soft_rst = 1;
      cyc(1);
      soft_rst = 0;
      rd("ol_soft", OPEN_LOAD_ADDR, 8'h00);
      // Selective wake activation gates
      mode_wr(3'h6);
      chk("act_noval", {7'h00, active}, 8'h00);
      cfg_ok = 1;
      mode_wr(3'h4);
      chk("act_100", {7'h00, active}, 8'h00);
      mode_wr(3'h6);
      wait_act(1);
      {f_ok, sil, wup, wuf} = 4'hf;
      cyc(1);
      {f_ok, sil, wup, wuf} = 4'h0;
      cyc(2);
      rd("swk_flags", SWK_STATUS_ADDR, 8'h4f);
      f_errs(3);
      restart = 1;
      cyc(1);
      restart = 0;
      cyc(20);
      rd("swk_restart", SWK_STATUS_ADDR, 8'h4f);
      rd("ecnt_restart", SWK_ERR_COUNT_ADDR, 8'h03);
      // Counter overflow blocks selective wake
      f_errs(30);
      chk("sys_err", {7'h00, sys_err}, 8'h01);
      chk("act_err", {7'h00, active}, 8'h00);
      rd("ecnt_sat", SWK_ERR_COUNT_ADDR, {2'b00, ECNT_OVERFLOW});
      // Overflow keeps setting the error while enabled, so the clear lands once disabled
      swk_clr = 1;
      cyc(1);
      swk_clr = 0;
      cyc(2);
      chk("sys_hold", {7'h00, sys_err}, 8'h01);
      mode_wr(3'h2);
      swk_clr = 1;
      cyc(1);
      swk_clr = 0;
      cyc(2);
      chk("sys_clr", {7'h00, sys_err}, 8'h00);
      soft_rst = 1;
      cyc(1);
      soft_rst = 0;
      rd("swk_soft", SWK_STATUS_ADDR, 8'h00);
      rd("ecnt_soft", SWK_ERR_COUNT_ADDR, 8'h00);
      // Config error reaches the system error only while selective wake is enabled
      cfg_err = 1;
      cyc(2);
      chk("err_off", {7'h00, sys_err}, 8'h00);
      mode_wr(3'h6);
      chk("err_on", {7'h00, sys_err}, 8'h01);
      chk("act_cfgerr", {7'h00, active}, 8'h00);
      cfg_err = 0;
      // Mid-run power-on reset; I/O levels show only when selected as general I/O
      arst_n_i = 0;
      dev = 1;
      io_pin = 2'h3;
      io_gpio = 2'h0;
      mode = MODE_NORMAL;
      cyc(2);
      arst_n_i = 1;
      cyc(2);
      rd("lvl_arst", INPUT_LEVEL_ADDR, 8'h80);
      io_gpio = 2'h2;
      cyc(2);
      rd("lvl_gpio", INPUT_LEVEL_ADDR, 8'ha0);
      wrap_up();
   end
endmodule
